// ==== rtcbc_pkg.sv ====
// Constants, register layouts and state types shared by the clock front end and its RAM.
// Assumes a single 100 MHz clock; all pins arrive synchronous to it.
package rtcbc_pkg;

    localparam int unsigned RTCBC_CLK_HZ    = 100_000_000;
    localparam int unsigned RTCBC_OSC_HZ    = 32768;
    localparam int unsigned RTCBC_HALF_CYC  = RTCBC_CLK_HZ / (2 * RTCBC_OSC_HZ);
    localparam int unsigned RTCBC_REC_MS    = 200;
    localparam int unsigned RTCBC_REC_CYC   = (RTCBC_CLK_HZ / 1000) * RTCBC_REC_MS;
    localparam int unsigned RTCBC_RAM_BYTES = 114;
    localparam int unsigned RTCBC_CHAIN_W   = 16;

    localparam logic [7:0] RTCBC_ADDR_REGA  = 8'h0a;
    localparam logic [7:0] RTCBC_ADDR_REGB  = 8'h0b;
    localparam logic [7:0] RTCBC_ADDR_REGC  = 8'h0c;
    localparam logic [7:0] RTCBC_ADDR_EXT   = 8'h4b;
    localparam logic [7:0] RTCBC_RAM_BASE   = 8'h0e;
    localparam logic [7:0] RTCBC_RAM_LAST   = 8'h7f;

    localparam logic [7:0] RTCBC_REGA_MASK  = 8'h7f;
    localparam logic [7:0] RTCBC_REGB_MASK  = 8'h68;
    localparam logic [7:0] RTCBC_EXT_MASK   = 8'hcb;

    localparam logic [3:0] RTCBC_RATE_MIN   = 4'h1;
    localparam logic [3:0] RTCBC_RATE_MAX   = 4'hd;
    localparam logic [3:0] RTCBC_TAP_BASE   = 4'h2;

    typedef struct packed {
        logic       busy_flag;
        logic       dv_rst;
        logic       oscillator_enable_bit;
        logic       bank;
        logic [3:0] rate;
    } rtcbc_rega_t;

    typedef struct packed {
        logic       rsv7;
        logic       pie;
        logic       aie;
        logic       rsv4;
        logic       wave_out_enable;
        logic [2:0] rsv2_0;
    } rtcbc_regb_t;

    typedef struct packed {
        logic       irqf;
        logic       pf;
        logic       af;
        logic       kf;
        logic [3:0] rsv3_0;
    } rtcbc_regc_t;

    typedef struct packed {
        logic       aux_supply_enable;
        logic       fast_clock_out_enable;
        logic [1:0] rsv5_4;
        logic       wipe_en;
        logic       rsv2;
        logic       pwr_on;
        logic       kie;
    } rtcbc_ext_t;

    typedef struct packed {
        rtcbc_rega_t rega;
        rtcbc_regb_t regb;
        rtcbc_ext_t  ext;
        logic        pf;
        logic        af;
        logic        kf;
        logic [7:0]  addr;
        logic        ale;
        logic        key;
        logic        rd_c;
        logic        tap_prev;
        logic        acc;
        logic [31:0] rec_cnt;
        logic [15:0] div_cnt;
        logic [RTCBC_CHAIN_W-1:0] chain;
        logic [7:0]  ad_out;
        logic        ad_oe;
        logic        irq_oe;
        logic        pwr_oe;
        logic        wave;
        logic        drv_lo;
    } rtcbc_state_t;

    localparam rtcbc_state_t RTCBC_STATE_RST = '{
        rega    : '{oscillator_enable_bit: 1'b1, default: '0},
        ext     : '{fast_clock_out_enable: 1'b1, default: '0},
        default : '0
    };

    typedef struct packed {
        logic       busy;
        logic [6:0] ptr;
        logic [7:0] rdata;
    } rtcbc_ram_st_t;

endpackage

// ==== rtcbc_ram.sv ====
// User RAM with registered read data and a sweeping wipe.
// Assumes the caller keeps write addresses below the depth.
`timescale 1ns/1ns
module rtcbc_ram import rtcbc_pkg::*; #(
    parameter int unsigned DEPTH = RTCBC_RAM_BYTES
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       we_in,
    input  wire logic [6:0] waddr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic [6:0] raddr_in,
    input  wire logic       wipe_in,
    output logic      [7:0] rdata_out,
    output logic            busy_out
);

    logic [7:0]    mem [DEPTH];
    rtcbc_ram_st_t s_q;
    rtcbc_ram_st_t s_d;
    logic          mem_we;
    logic [6:0]    mem_a;
    logic [7:0]    mem_d;

    ////////////////////////////////////////////////////////////////////////////////
    // A wipe runs the whole sweep once started, so a short pulse still clears every byte.
    always_comb begin
        s_d    = s_q;
        mem_we = we_in;
        mem_a  = waddr_in;
        mem_d  = wdata_in;
        if (wipe_in || s_q.busy) begin
            mem_we = 1'b1;
            mem_a  = s_q.ptr;
            mem_d  = '0;
            if (s_q.ptr == 7'(DEPTH - 1)) begin
                s_d.ptr  = '0;
                s_d.busy = 1'b0;
            end else begin
                s_d.ptr  = s_q.ptr + 7'h01;
                s_d.busy = 1'b1;
            end
        end
        s_d.rdata = (raddr_in < 7'(DEPTH)) ? mem[raddr_in] : '0;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (mem_we) begin
            mem[mem_a] <= mem_d;
        end
    end

    assign rdata_out = s_q.rdata;
    assign busy_out  = s_q.busy;

endmodule

// ==== rtcbc_top.sv ====
// Pin-level front end of a battery-backed clock: multiplexed bus, wave, interrupt, power pins.
// Assumes all pins are synchronous to CLK_IN and supply sensing arrives as clean levels.
`timescale 1ns/1ns
module rtcbc_top import rtcbc_pkg::*; #(
    parameter int unsigned REC_CYCLES = RTCBC_REC_CYC
) (
    input  wire logic       CLK_IN,
    input  wire logic       RESET_IN,
    input  wire logic       MAIN_POWER_OK_IN,
    input  wire logic       AUX_BATTERY_SUPPLY_IN,
    input  wire logic [7:0] SHARED_BUS_LINES_IN,
    output logic      [7:0] SHARED_BUS_LINES_OUT,
    output logic            SHARED_BUS_LINES_OE_OUT,
    input  wire logic       ALE_IN,
    input  wire logic       CS_N_IN,
    input  wire logic       RD_N_IN,
    input  wire logic       WR_N_IN,
    input  wire logic       KEY_WAKE_INPUT_N_IN,
    input  wire logic       USER_RAM_WIPE_N_IN,
    input  wire logic       ALARM_WAKE_IN,
    output logic            SQUARE_WAVE_OUT,
    output logic            IRQ_N_OUT,
    output logic            IRQ_OE_OUT,
    output logic            SYSTEM_POWER_ON_N_OUT,
    output logic            SYSTEM_POWER_ON_OE_OUT
);

    rtcbc_state_t s_q;
    rtcbc_state_t s_d;
    rtcbc_regc_t  regc;
    logic         pwr_ok;
    logic         tick;
    logic         rate_ok;
    logic [3:0]   tap_idx;
    logic         tap_lvl;
    logic         sel;
    logic         wr_ok;
    logic         rd_ok;
    logic         is_ext;
    logic         in_ram;
    logic         ram_we;
    logic         c_clr;
    logic         key_fall;
    logic         irq_any;
    logic [7:0]   ram_rdata;
    logic         ram_busy;
    logic [6:0]   ram_idx;

    ////////////////////////////////////////////////////////////////////////////////
    // Divider chain, bus decode and event flags.
    always_comb begin
        s_d    = s_q;
        pwr_ok = MAIN_POWER_OK_IN;

        if (!pwr_ok) begin
            s_d.rec_cnt = '0;
            s_d.acc     = 1'b0;
        end else begin
            if (s_q.rec_cnt != 32'(REC_CYCLES)) begin
                s_d.rec_cnt = s_q.rec_cnt + 32'h1;
            end
            // Once open the bus stays open until main power fails, so a divider reset by software cannot lock it out.
            if (s_q.rec_cnt == 32'(REC_CYCLES) && s_q.rega.oscillator_enable_bit
                && !s_q.rega.dv_rst) begin
                s_d.acc = 1'b1;
            end
        end

        tick = (s_q.div_cnt == 16'(RTCBC_HALF_CYC - 1));
        s_d.div_cnt = tick ? '0 : s_q.div_cnt + 16'h1;
        if (s_q.rega.dv_rst) begin
            s_d.chain = '0;
        end else if (tick && s_q.rega.oscillator_enable_bit) begin
            s_d.chain = s_q.chain + 16'h1;
        end
        rate_ok = (s_q.rega.rate >= RTCBC_RATE_MIN) && (s_q.rega.rate <= RTCBC_RATE_MAX);
        tap_idx = s_q.rega.rate + RTCBC_TAP_BASE;
        tap_lvl = rate_ok && s_q.chain[tap_idx];
        s_d.tap_prev = tap_lvl;

        s_d.ale = ALE_IN;
        if (pwr_ok && s_q.ale && !ALE_IN) begin
            s_d.addr = SHARED_BUS_LINES_IN;
        end
        sel    = s_q.acc && pwr_ok && !CS_N_IN;
        wr_ok  = sel && !WR_N_IN;
        rd_ok  = sel && !RD_N_IN;
        is_ext = s_q.rega.bank && (s_q.addr == RTCBC_ADDR_EXT);
        in_ram = (s_q.addr >= RTCBC_RAM_BASE) && (s_q.addr <= RTCBC_RAM_LAST) && !is_ext;
        ram_idx = 7'(s_q.addr - RTCBC_RAM_BASE);
        ram_we  = wr_ok && in_ram && !ram_busy;

        // The last cycle of the store strobe leaves the final bus value in place.
        if (wr_ok) begin
            if (is_ext) begin
                s_d.ext = rtcbc_ext_t'(SHARED_BUS_LINES_IN & RTCBC_EXT_MASK);
            end else if (s_q.addr == RTCBC_ADDR_REGA) begin
                s_d.rega = rtcbc_rega_t'(SHARED_BUS_LINES_IN & RTCBC_REGA_MASK);
            end else if (s_q.addr == RTCBC_ADDR_REGB) begin
                s_d.regb = rtcbc_regb_t'(SHARED_BUS_LINES_IN & RTCBC_REGB_MASK);
            end
        end

        s_d.rd_c = rd_ok && (s_q.addr == RTCBC_ADDR_REGC);
        c_clr    = s_q.rd_c && !rd_ok;
        key_fall = s_q.key && !KEY_WAKE_INPUT_N_IN;
        s_d.key  = KEY_WAKE_INPUT_N_IN;

        // A flag set in the cycle of its clear survives the clear.
        s_d.pf = (tap_lvl && !s_q.tap_prev) || (s_q.pf && !c_clr);
        s_d.af = ALARM_WAKE_IN || (s_q.af && !c_clr);
        s_d.kf = (pwr_ok && key_fall) || (s_q.kf && !c_clr);

        if (!pwr_ok && ((key_fall && AUX_BATTERY_SUPPLY_IN && s_q.ext.aux_supply_enable)
            || (s_q.af && s_q.regb.aie))) begin
            s_d.ext.pwr_on = 1'b1;
        end

        irq_any = (s_q.pf && s_q.regb.pie) || (s_q.af && s_q.regb.aie)
                  || (s_q.kf && s_q.ext.kie);
        regc = '{irqf: irq_any, pf: s_q.pf, af: s_q.af, kf: s_q.kf, rsv3_0: '0};

        s_d.irq_oe = pwr_ok && irq_any;
        s_d.pwr_oe = s_q.ext.pwr_on;
        s_d.ad_oe  = rd_ok;
        if (is_ext) begin
            s_d.ad_out = s_q.ext;
        end else if (s_q.addr == RTCBC_ADDR_REGA) begin
            s_d.ad_out = s_q.rega;
        end else if (s_q.addr == RTCBC_ADDR_REGB) begin
            s_d.ad_out = s_q.regb;
        end else if (s_q.addr == RTCBC_ADDR_REGC) begin
            s_d.ad_out = regc;
        end else if (in_ram) begin
            s_d.ad_out = ram_rdata;
        end else begin
            s_d.ad_out = '0;
        end

        if (!s_q.rega.oscillator_enable_bit) begin
            s_d.wave = 1'b0;
        end else if (pwr_ok) begin
            if (s_q.ext.fast_clock_out_enable) begin
                s_d.wave = s_q.chain[0];
            end else begin
                s_d.wave = s_q.regb.wave_out_enable && tap_lvl;
            end
        end else begin
            // Below the fail point only the auxiliary cell can keep the fast wave alive.
            s_d.wave = s_q.ext.fast_clock_out_enable && s_q.ext.aux_supply_enable
                       && AUX_BATTERY_SUPPLY_IN && s_q.chain[0];
        end
        s_d.drv_lo = 1'b0;
    end

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            s_q <= RTCBC_STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    rtcbc_ram #(
        .DEPTH (RTCBC_RAM_BYTES)
    ) u_ram (
        .clk_in    (CLK_IN),
        .rst_in    (RESET_IN),
        .we_in     (ram_we),
        .waddr_in  (ram_idx),
        .wdata_in  (SHARED_BUS_LINES_IN),
        .raddr_in  (ram_idx),
        .wipe_in   (!USER_RAM_WIPE_N_IN && s_q.ext.wipe_en),
        .rdata_out (ram_rdata),
        .busy_out  (ram_busy)
    );

    assign SHARED_BUS_LINES_OUT    = s_q.ad_out;
    assign SHARED_BUS_LINES_OE_OUT = s_q.ad_oe;
    assign SQUARE_WAVE_OUT         = s_q.wave;
    assign IRQ_N_OUT               = s_q.drv_lo;
    assign IRQ_OE_OUT              = s_q.irq_oe;
    assign SYSTEM_POWER_ON_N_OUT   = s_q.drv_lo;
    assign SYSTEM_POWER_ON_OE_OUT  = s_q.pwr_oe;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the pins against their causes.
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    a_powerup_fast: assert property ($past(RESET_IN) |->
        s_q.ext.fast_clock_out_enable && s_q.rega.oscillator_enable_bit)
        else $error("Power-up did not set the wave enables.");
    a_wave_off: assert property (!s_q.regb.wave_out_enable
        && !s_q.ext.fast_clock_out_enable |=> !SQUARE_WAVE_OUT)
        else $error("Wave driven with both enables clear.");
    // A half period is too long for a delay range, so the check rides on the divider tick.
    a_fast_wave: assert property (tick && MAIN_POWER_OK_IN && !s_q.rega.dv_rst
        && s_q.ext.fast_clock_out_enable && s_q.rega.oscillator_enable_bit
        ##1 MAIN_POWER_OK_IN && s_q.ext.fast_clock_out_enable
        && s_q.rega.oscillator_enable_bit |=> $changed(SQUARE_WAVE_OUT))
        else $error("Fast wave did not follow the divider tick.");
    a_lowpwr_wave: assert property (!MAIN_POWER_OK_IN && !(s_q.ext.aux_supply_enable
        && AUX_BATTERY_SUPPLY_IN) |=> !SQUARE_WAVE_OUT)
        else $error("Wave driven below fail point without aux.");
    a_addr_latch: assert property (MAIN_POWER_OK_IN && $fell(ALE_IN)
        |=> s_q.addr == $past(SHARED_BUS_LINES_IN))
        else $error("Address not captured on strobe fall.");
    a_rd_release: assert property ($rose(RD_N_IN) |=> !SHARED_BUS_LINES_OE_OUT)
        else $error("Bus not released after read strobe.");
    a_rd_drive_gate: assert property (SHARED_BUS_LINES_OE_OUT |->
        $past(!RD_N_IN && !CS_N_IN && s_q.acc))
        else $error("Bus driven outside a selected read.");
    a_ram_write_gate: assert property (ram_we |-> !WR_N_IN && !CS_N_IN)
        else $error("RAM written outside a selected store.");
    a_irq_follow: assert property (MAIN_POWER_OK_IN ##1 MAIN_POWER_OK_IN
        |-> IRQ_OE_OUT == $past(irq_any))
        else $error("Interrupt pin does not follow enabled flags.");
    a_key_power: assert property (!MAIN_POWER_OK_IN && $fell(KEY_WAKE_INPUT_N_IN)
        && AUX_BATTERY_SUPPLY_IN && s_q.ext.aux_supply_enable ##1 1 |=> SYSTEM_POWER_ON_OE_OUT)
        else $error("Kickstart did not assert power-on.");
    a_key_flag: assert property (MAIN_POWER_OK_IN && $fell(KEY_WAKE_INPUT_N_IN)
        |=> s_q.kf)
        else $error("Key edge did not raise its flag.");
    a_wipe_start: assert property ($rose(!USER_RAM_WIPE_N_IN && s_q.ext.wipe_en)
        && !ram_busy |=> ram_busy [*8])
        else $error("RAM wipe did not start.");
    a_lockout: assert property (!MAIN_POWER_OK_IN
        |=> !s_q.acc ##1 !SHARED_BUS_LINES_OE_OUT)
        else $error("Bus open below fail point.");

    c_read: cover property (rd_ok ##1 SHARED_BUS_LINES_OE_OUT);
    c_write: cover property (ram_we);
    c_kick: cover property (!MAIN_POWER_OK_IN ##1 $rose(SYSTEM_POWER_ON_OE_OUT));
    c_irq: cover property ($rose(IRQ_OE_OUT) ##[1:50] $fell(IRQ_OE_OUT));

endmodule

// ==== rtcbc_host.sv ====
// Host processor model for the multiplexed address and data bus.
// Assumes the clock front end drives the lines only while its enable is high.
`timescale 1ns/1ns
module rtcbc_host (
    input  wire logic       clk_in,
    input  wire logic       oe_in,
    input  wire logic [7:0] dout_in,
    output logic      [7:0] bus_out,
    output logic            ale_out,
    output logic            cs_n_out,
    output logic            rd_n_out,
    output logic            wr_n_out
);
    logic [7:0] drv_q = 8'h00;

    // Released lines show the inverse of the last byte, so stale data never looks valid.
    assign bus_out = oe_in ? dout_in : drv_q;

    initial begin
        ale_out  = 1'b0;
        cs_n_out = 1'b1;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic adr(input logic [7:0] a);
        @(posedge clk_in);
        ale_out <= 1'b1;
        drv_q   <= a;
        @(posedge clk_in);
        ale_out <= 1'b0;
        @(posedge clk_in);
        drv_q   <= ~a;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic cs_n);
        adr(a);
        @(posedge clk_in);
        cs_n_out <= cs_n;
        wr_n_out <= 1'b0;
        drv_q    <= d;
        repeat (2) @(posedge clk_in);
        cs_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        drv_q    <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, input logic new_a, output logic [7:0] q,
                      output logic ok);
        ok = 1'b0;
        q  = 8'h00;
        if (new_a) begin
            adr(a);
        end
        repeat (2) @(posedge clk_in);
        cs_n_out <= 1'b0;
        rd_n_out <= 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge clk_in);
            ok = (oe_in === 1'b1);
            q  = dout_in;
        end
        cs_n_out <= 1'b1;
        rd_n_out <= 1'b1;
    endtask
endmodule

// ==== tb.sv ====
// Self-checking bench for the clock front end: bus, wave, interrupt, power and wipe pins.
// Assumes the host model owns the bus strobes; the bench drives supplies, key, wipe, alarm.
`timescale 1ns/1ns
module tb import rtcbc_pkg::*;;
    localparam int unsigned REC = 40;
    localparam logic [15:0] HALF = 16'(RTCBC_HALF_CYC);

    logic       clk    = 1'b0;
    logic       rst    = 1'b1;
    logic       pwr_ok = 1'b1;
    logic       aux    = 1'b1;
    logic       key_n  = 1'b1;
    logic       wipe_n = 1'b1;
    logic       alarm  = 1'b0;
    logic [7:0] bus;
    logic [7:0] dout;
    logic       oe;
    logic       ale;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       wave;
    logic       irq_n;
    logic       irq_oe;
    logic       pon_n;
    logic       pon_oe;
    logic [7:0] q;
    logic       ok;
    int         h;
    int         errors    = 0;
    int         cmp_count = 0;

    always #5 clk = ~clk;

    rtcbc_top #(.REC_CYCLES(REC)) dut (
        .CLK_IN                 (clk),
        .RESET_IN               (rst),
        .MAIN_POWER_OK_IN       (pwr_ok),
        .AUX_BATTERY_SUPPLY_IN  (aux),
        .SHARED_BUS_LINES_IN    (bus),
        .SHARED_BUS_LINES_OUT   (dout),
        .SHARED_BUS_LINES_OE_OUT(oe),
        .ALE_IN                 (ale),
        .CS_N_IN                (cs_n),
        .RD_N_IN                (rd_n),
        .WR_N_IN                (wr_n),
        .KEY_WAKE_INPUT_N_IN    (key_n),
        .USER_RAM_WIPE_N_IN     (wipe_n),
        .ALARM_WAKE_IN          (alarm),
        .SQUARE_WAVE_OUT        (wave),
        .IRQ_N_OUT              (irq_n),
        .IRQ_OE_OUT             (irq_oe),
        .SYSTEM_POWER_ON_N_OUT  (pon_n),
        .SYSTEM_POWER_ON_OE_OUT (pon_oe)
    );

    rtcbc_host host (
        .clk_in  (clk),
        .oe_in   (oe),
        .dout_in (dout),
        .bus_out (bus),
        .ale_out (ale),
        .cs_n_out(cs_n),
        .rd_n_out(rd_n),
        .wr_n_out(wr_n)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic chkb(string nm, logic s, logic e);
        chk(nm, {15'h0, s}, {15'h0, e});
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask

    // A read that never sees the drivers turn on within eight cycles ends the run.
    task automatic rdn(string nm, logic [7:0] a, logic new_a, logic [7:0] e);
        host.rd(a, new_a, q, ok);
        chk(nm, {7'h0, ok, q}, {8'h01, e});
        if (!ok) begin
            complete_run();
        end
        cyc(2);
        chkb("oe_release", oe, 1'b0);
    endtask

    task automatic half(output int n);
        logic s;
        int   i;
        s = wave;
        for (i = 0; i < 20000 && wave === s; i++) @(posedge clk);
        s = wave;
        for (n = 0; n < 20000 && wave === s; n++) @(posedge clk);
        if (i == 20000 || n == 20000) begin
            errors++;
            complete_run();
        end
    endtask

    task automatic quiet(string nm);
        logic bad;
        bad = 1'b0;
        repeat (1600) begin
            @(posedge clk);
            bad |= (wave !== 1'b0);
        end
        chkb(nm, bad, 1'b0);
    endtask

    task automatic keyfall();
        key_n <= 1'b0;
        cyc(4);
        key_n <= 1'b1;
        cyc(4);
    endtask

    task automatic pulse_alarm();
        alarm <= 1'b1;
        cyc(1);
        alarm <= 1'b0;
        cyc(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(6);
        rst <= 1'b0;
        host.rd(RTCBC_ADDR_REGA, 1'b1, q, ok);
        chkb("early_read", ok, 1'b0);
        cyc(REC + 20);
        rdn("rega_reset", RTCBC_ADDR_REGA, 1'b1, 8'h20);
        host.wr(RTCBC_ADDR_REGA, 8'h30, 1'b0);
        rdn("ext_reset", RTCBC_ADDR_EXT, 1'b1, 8'h40);
        half(h);
        chk("fast_half", 16'(h), HALF);
        host.wr(8'h20, 8'ha5, 1'b0);
        host.wr(8'h21, 8'h5a, 1'b0);
        rdn("ram20", 8'h20, 1'b1, 8'ha5);
        rdn("ram21", 8'h21, 1'b1, 8'h5a);
        // The deselected store must move the pointer from 21 to 20 and leave the byte alone.
        host.wr(8'h20, 8'h3c, 1'b1);
        rdn("desel_latch", 8'h00, 1'b0, 8'ha5);
        rdn("reuse_addr", 8'h00, 1'b0, 8'ha5);
        host.wr(RTCBC_ADDR_EXT, 8'h00, 1'b0);
        cyc(2);
        quiet("wave_off");
        host.wr(RTCBC_ADDR_REGB, 8'h08, 1'b0);
        host.wr(RTCBC_ADDR_REGA, 8'h31, 1'b0);
        half(h);
        half(h);
        chk("rate1_half", 16'(h), 16'(8 * RTCBC_HALF_CYC));
        host.wr(RTCBC_ADDR_REGA, 8'h30, 1'b0);
        // The rate test leaves the periodic flag set; clear it before the key test reads status.
        rdn("regc_rate", RTCBC_ADDR_REGC, 1'b1, 8'h40);
        host.wr(RTCBC_ADDR_EXT, 8'h01, 1'b0);
        keyfall();
        chkb("irq_key", irq_oe, 1'b1);
        chkb("irq_level", irq_n, 1'b0);
        rdn("regc_key", RTCBC_ADDR_REGC, 1'b1, 8'h90);
        cyc(2);
        chkb("irq_clear", irq_oe, 1'b0);
        host.wr(RTCBC_ADDR_EXT, 8'h00, 1'b0);
        keyfall();
        chkb("irq_masked", irq_oe, 1'b0);
        rdn("regc_masked", RTCBC_ADDR_REGC, 1'b1, 8'h10);
        host.wr(RTCBC_ADDR_REGB, 8'h20, 1'b0);
        pulse_alarm();
        chkb("irq_alarm", irq_oe, 1'b1);
        rdn("regc_alarm", RTCBC_ADDR_REGC, 1'b1, 8'ha0);
        for (int e = 0; e < 2; e++) begin
            host.wr(RTCBC_ADDR_EXT, (e == 1) ? 8'h08 : 8'h00, 1'b0);
            wipe_n <= 1'b0;
            cyc(3);
            wipe_n <= 1'b1;
            cyc(130);
            rdn("wipe", 8'h20, 1'b1, (e == 1) ? 8'h00 : 8'ha5);
        end
        host.wr(RTCBC_ADDR_EXT, 8'hc0, 1'b0);
        pwr_ok <= 1'b0;
        half(h);
        half(h);
        chk("aux_wave", 16'(h), HALF);
        aux <= 1'b0;
        cyc(2);
        quiet("no_aux_wave");
        keyfall();
        chkb("pon_no_aux", pon_oe, 1'b0);
        aux <= 1'b1;
        keyfall();
        chkb("pon_key", pon_oe, 1'b1);
        chkb("pon_level", pon_n, 1'b0);
        pwr_ok <= 1'b1;
        cyc(REC + 20);
        host.wr(RTCBC_ADDR_EXT, 8'h00, 1'b0);
        cyc(3);
        chkb("pon_release", pon_oe, 1'b0);
        pwr_ok <= 1'b0;
        pulse_alarm();
        chkb("pon_alarm", pon_oe, 1'b1);
        // A second power-up in mid-run must restore the defaults and drop the power pin.
        pwr_ok <= 1'b1;
        rst    <= 1'b1;
        cyc(2);
        rst    <= 1'b0;
        cyc(REC + 20);
        chkb("pon_reset", pon_oe, 1'b0);
        rdn("rega_rerst", RTCBC_ADDR_REGA, 1'b1, 8'h20);
        complete_run();
    end
endmodule
